// [design/ssw_cfg.svh]
`ifndef SSW_CFG_SVH
`define SSW_CFG_SVH

// Supervisor timing at a 200 MHz system clock
`define SSW_CLK_MHZ        200
`define SSW_RST_TIMEOUT_MS 200
`define SSW_WD_PERIOD_MS   1600
`define SSW_RST_TIMEOUT_CYC (`SSW_RST_TIMEOUT_MS * 1000 * `SSW_CLK_MHZ)
`define SSW_WD_PERIOD_CYC   (`SSW_WD_PERIOD_MS * 1000 * `SSW_CLK_MHZ)
`define SSW_CNT_W          32
`define SSW_SYNC_STAGES    2

`endif

// [design/ssw_pkg.sv]
package ssw_pkg;

  typedef struct packed {
    logic below_reset;
    logic below_warn;
    logic below_backup;
  } ssw_cmp_type;

  typedef enum logic [2:0] {
    ST_POR  = 3'b001,
    ST_HOLD = 3'b010,
    ST_RUN  = 3'b100
  } ssw_state_type;

  typedef struct packed {
    logic rst_n;
    logic rst;
    logic warn_n;
    logic on_backup;
  } ssw_out_type;

endpackage

// [design/ssw_sync.sv]
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser, one per bit
module ssw_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk_i,  // System clock
  input  wire logic             rst_n_i,    // Async reset, active low
  input  wire logic [WIDTH-1:0] async_i,    // Asynchronous input
  output logic      [WIDTH-1:0] sync_o      // Synchronised output
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync;

  always_comb
  begin
    next_meta = async_i;
    next_sync = meta;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta   <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta   <= next_meta;
      sync_o <= next_sync;
    end
  end
endmodule
`default_nettype wire

// [design/ssw_supervisor.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ssw_cfg.svh"
module ssw_supervisor #(
  parameter int unsigned RST_TIMEOUT_CYC = `SSW_RST_TIMEOUT_CYC,
  parameter int unsigned WD_PERIOD_CYC   = `SSW_WD_PERIOD_CYC
) (
  input  wire logic sys_clk_i,            // System clock, 200 MHz
  input  wire logic rst_n_i,              // Power-on reset, async, active low
  input  wire logic vcc_below_reset_i,    // Comparator: supply below reset level
  input  wire logic vcc_below_warn_i,     // Comparator: supply below warning level
  input  wire logic vcc_below_cell_i,     // Comparator: supply below backup cell
  input  wire logic watchdog_kick_in_i,   // Watchdog kick from processor pin
  input  wire logic watchdog_kick_valid_i, // Low when kick pin floats
  input  wire logic ce_n_i,               // Incoming chip-enable, active low
  output logic      reset_n_o,            // Processor reset, active low
  output logic      reset_o,              // Processor reset, active high
  output logic      power_fail_warn_n_o,  // Early power-fail warning, active low
  output logic      backup_cell_supply_o, // High selects the backup cell
  output logic      ce_n_o                // Gated chip-enable, active low
);
  localparam int CW = `SSW_CNT_W;

  // Zero counts would wrap each minus-one compare to all ones: a near-maximal reset timeout and a watchdog that almost never fires
  if (RST_TIMEOUT_CYC < 1 || WD_PERIOD_CYC < 1)
  begin : g_bad_counts
    $error("ssw_supervisor: counts must be at least one");
  end

  // Comparator and kick pins are asynchronous: two flops guard the counters
  logic [4:0] pin_sync;
  ssw_sync #(.WIDTH(5)) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   ({vcc_below_reset_i, vcc_below_warn_i, vcc_below_cell_i,
                 watchdog_kick_in_i, watchdog_kick_valid_i}),
    .sync_o    (pin_sync)
  );

  ssw_pkg::ssw_cmp_type cmp;
  logic kick;
  logic kick_ok;
  assign cmp     = '{below_reset: pin_sync[4], below_warn: pin_sync[3],
                     below_backup: pin_sync[2]};
  assign kick    = pin_sync[1];
  assign kick_ok = pin_sync[0];

  // POR lasts one cycle, so HOLD starts counting while the second synchroniser flop still holds its reset value
  ssw_pkg::ssw_state_type state;
  ssw_pkg::ssw_state_type next_state;
  logic [CW-1:0] hold_cnt;
  logic [CW-1:0] next_hold_cnt;
  logic [CW-1:0] wd_cnt;
  logic [CW-1:0] next_wd_cnt;
  logic          kick_q;
  logic          next_kick_q;
  logic          wd_expire;
  ssw_pkg::ssw_out_type outs;
  ssw_pkg::ssw_out_type next_outs;

  // Kick edge detect on the synchronised copy only
  assign wd_expire = kick_ok && (wd_cnt >= CW'(WD_PERIOD_CYC - 1))
                     && (kick == kick_q);

  always_comb
  begin
    next_state    = state;
    next_hold_cnt = hold_cnt;
    next_wd_cnt   = wd_cnt;
    next_kick_q   = kick;
    case (state)
      ssw_pkg::ST_POR:
      begin
        next_state    = ssw_pkg::ST_HOLD;
        next_hold_cnt = '0;
      end
      ssw_pkg::ST_HOLD:
      begin
        next_wd_cnt = '0;
        if (cmp.below_reset)
          next_hold_cnt = '0;
        else if (hold_cnt >= CW'(RST_TIMEOUT_CYC - 1))
        begin
          next_state    = ssw_pkg::ST_RUN;
          next_hold_cnt = '0;
        end
        else
          next_hold_cnt = hold_cnt + CW'(1);
      end
      ssw_pkg::ST_RUN:
      begin
        if (cmp.below_reset || wd_expire)
        begin
          next_state    = ssw_pkg::ST_HOLD;
          next_hold_cnt = '0;
          next_wd_cnt   = '0;
        end
        // An open pin clears rather than pauses, so a reconnect starts a full period
        else if (!kick_ok || kick != kick_q)
          next_wd_cnt = '0;
        else
          next_wd_cnt = wd_cnt + CW'(1);
      end
      default:
        next_state = ssw_pkg::ST_POR;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state    <= ssw_pkg::ST_POR;
      hold_cnt <= '0;
      wd_cnt   <= '0;
      // Idle pin level is unknown; a false edge only clears a count HOLD clears anyway
      kick_q   <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      hold_cnt <= next_hold_cnt;
      wd_cnt   <= next_wd_cnt;
      kick_q   <= next_kick_q;
    end
  end

  // Outputs registered from next-state so reset tracks the state exactly
  // Warning and supply select share the sync delay, so they move with reset
  always_comb
  begin
    next_outs.rst_n     = (next_state == ssw_pkg::ST_RUN);
    next_outs.rst       = !(next_state == ssw_pkg::ST_RUN);
    next_outs.warn_n    = !cmp.below_warn;
    next_outs.on_backup = cmp.below_reset && cmp.below_backup;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      outs <= '{rst_n: 1'b0, rst: 1'b1, warn_n: 1'b0, on_backup: 1'b0};
    else
      outs <= next_outs;
  end

  assign reset_n_o          = outs.rst_n;
  assign reset_o            = outs.rst;
  assign power_fail_warn_n_o  = outs.warn_n;
  assign backup_cell_supply_o = outs.on_backup;
  // Combinational path keeps the gate transparent; registering would add latency
  assign ce_n_o = outs.rst_n ? ce_n_i : 1'b1;

  // Checks below use the synchronised comparator copies, as the logic does
  AST_INVERSE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    reset_o == !reset_n_o) else $error("reset outputs not inverse");
  AST_LOW_HOLD: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    cmp.below_reset |=> !reset_n_o) else $error("reset released while below");
  AST_CE_GATE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !reset_n_o |-> ce_n_o) else $error("chip-enable leaked in reset");
  AST_CE_PASS: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    reset_n_o |-> ce_n_o == ce_n_i) else $error("chip-enable not passed");
  AST_BACKUP: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    backup_cell_supply_o == $past(cmp.below_reset && cmp.below_backup))
    else $error("supply select wrong");
  AST_WARN: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $past(rst_n_i) |-> power_fail_warn_n_o == !$past(cmp.below_warn))
    else $error("warning wrong");
  AST_RESTART: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state == ssw_pkg::ST_HOLD && cmp.below_reset) |=> hold_cnt == '0)
    else $error("timeout not restarted");
  AST_WD_CLEAR: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !reset_n_o |-> wd_cnt == '0) else $error("watchdog counts in reset");
  sequence s_expire;
    state == ssw_pkg::ST_RUN && wd_expire && !cmp.below_reset;
  endsequence
  AST_WD_RESET: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    s_expire |=> !reset_n_o ##1 (hold_cnt == CW'(1))) else $error("no watchdog reset");
  AST_RELEASE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state == ssw_pkg::ST_HOLD && !cmp.below_reset
     && hold_cnt == CW'(RST_TIMEOUT_CYC - 1)) |=> reset_n_o)
    else $error("reset not released after timeout");

  // Watchdog steps: an open kick pin, and a seen kick edge, each clear the count
  sequence s_run_float;
    state == ssw_pkg::ST_RUN && !kick_ok;
  endsequence
  sequence s_run_kick;
    state == ssw_pkg::ST_RUN && kick_ok && (kick != kick_q);
  endsequence
  AST_WD_FLOAT: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    s_run_float |=> wd_cnt == '0) else $error("watchdog counts with open pin");
  AST_WD_KICK: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    s_run_kick |=> wd_cnt == '0) else $error("kick edge not seen");
  AST_WD_LIMIT: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    state == ssw_pkg::ST_RUN |-> wd_cnt <= CW'(WD_PERIOD_CYC - 1))
    else $error("watchdog ran past its period");
  AST_MAIN_SUPPLY: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (!cmp.below_reset || !cmp.below_backup) |=> !backup_cell_supply_o)
    else $error("backup cell selected above threshold");
  AST_HOLD_LIMIT: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    state == ssw_pkg::ST_HOLD |-> hold_cnt < CW'(RST_TIMEOUT_CYC))
    else $error("reset timeout count out of range");
  AST_POR_STEP: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    state == ssw_pkg::ST_POR |=> state == ssw_pkg::ST_HOLD && !reset_n_o)
    else $error("power-on step skipped");
endmodule
`default_nettype wire

// [dv/ssw_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Processor side: toggles the kick pin while out of reset, or leaves it open
module ssw_cpu_model #(
  parameter int GAP = 20
) (
  input  wire logic sys_clk_i,  // System clock
  input  wire logic reset_n_i,  // Reset from the supervisor
  input  wire logic kick_en_i,  // Bench allows toggling
  input  wire logic float_i,    // Bench leaves the kick pin open
  output logic      kick_o,     // Kick pin level
  output logic      valid_o     // Kick pin at a valid level
);
  int   cnt      = 0;
  logic float_q  = 1'b0;
  logic kick_lvl = 1'b0;
  assign kick_o  = kick_lvl;
  assign valid_o = !float_i;
  always @(posedge sys_clk_i)
  begin
    float_q <= float_i;
    // An open pin no longer shows the last driven level
    if (float_i && !float_q)
      kick_lvl <= !kick_lvl;
    if (!reset_n_i || !kick_en_i || float_i)
      cnt <= 0;
    else if (cnt == GAP - 1)
    begin
      cnt    <= 0;
      kick_lvl <= !kick_lvl;
    end
    else
      cnt <= cnt + 1;
  end
endmodule
`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic blw_rst = 1'b0;
  logic blw_warn = 1'b0;
  logic blw_cell = 1'b0;
  logic ce_n = 1'b1;
  logic kick_en = 1'b1;
  logic flt = 1'b0;
  logic kick, kick_ok, reset_n_o, reset_o, warn_n, on_cell, ce_n_o;
  int   err_count = 0;
  int   checks_done = 0;
  int   n;
  ssw_supervisor #(.RST_TIMEOUT_CYC(20), .WD_PERIOD_CYC(50)) u_ssw_supervisor (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .vcc_below_reset_i(blw_rst),
    .vcc_below_warn_i(blw_warn), .vcc_below_cell_i(blw_cell),
    .watchdog_kick_in_i(kick), .watchdog_kick_valid_i(kick_ok), .ce_n_i(ce_n),
    .reset_n_o(reset_n_o), .reset_o(reset_o), .power_fail_warn_n_o(warn_n),
    .backup_cell_supply_o(on_cell), .ce_n_o(ce_n_o));
  ssw_cpu_model #(.GAP(20)) u_ssw_cpu_model (
    .sys_clk_i(sys_clk), .reset_n_i(reset_n_o), .kick_en_i(kick_en),
    .float_i(flt), .kick_o(kick), .valid_o(kick_ok));
  initial forever #2.5 sys_clk = !sys_clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  // Bounded wait for the reset output to reach a level
  task automatic wait_rst(input logic lvl, input int lim, output int k);
    k = 0;
    while (reset_n_o !== lvl && k < lim)
    begin
      @(posedge sys_clk);
      k++;
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic t_supply_low;
    @(posedge sys_clk);
    blw_warn <= 1'b1;
    cyc(5);
    chk(warn_n, 1'b0, "warning late");
    chk(reset_n_o, 1'b1, "reset on warning alone");
    @(posedge sys_clk);
    {blw_rst, blw_warn, blw_cell, ce_n} <= 4'he;
    cyc(6);
    chk(reset_n_o, 1'b0, "reset not held low");
    chk(reset_o, 1'b1, "active-high reset wrong");
    chk(warn_n, 1'b0, "warning not low");
    chk(on_cell, 1'b1, "backup cell not selected");
    chk(ce_n_o, 1'b1, "chip-enable not blocked");
    @(posedge sys_clk);
    blw_cell <= 1'b0;
    cyc(5);
    chk(on_cell, 1'b0, "cell selected above cell level");
    $display("test supply_low done");
  endtask
  task automatic t_recover;
    @(posedge sys_clk);
    {blw_rst, blw_warn, blw_cell} <= 3'h1;
    cyc(10);
    blw_rst <= 1'b1;
    cyc(5);
    blw_rst <= 1'b0;
    cyc(15);
    chk(reset_n_o, 1'b0, "timeout not restarted");
    chk(on_cell, 1'b0, "cell selected above reset level");
    chk(warn_n, 1'b1, "warning stuck low");
    wait_rst(1'b1, 30, n);
    chk(n >= 5 && n < 30, 1'b1, "reset release time");
    chk(reset_o, 1'b0, "active-high reset after release");
    $display("test recover done");
  endtask
  task automatic t_ce_pass;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge sys_clk);
      ce_n <= i[0];
      @(posedge sys_clk);
      chk(ce_n_o, i[0], "chip-enable not passed");
    end
    $display("test ce_pass done");
  endtask
  task automatic t_watchdog;
    cyc(200);
    chk(reset_n_o, 1'b1, "reset despite kicks");
    @(posedge sys_clk);
    kick_en <= 1'b0;
    wait_rst(1'b0, 80, n);
    chk(n > 30 && n < 60, 1'b1, "watchdog expiry time");
    chk(reset_o, 1'b1, "active-high reset on expiry");
    wait_rst(1'b1, 40, n);
    chk(n >= 15 && n < 30, 1'b1, "watchdog reset length");
    kick_en <= 1'b1;
    $display("test watchdog done");
  endtask
  task automatic t_float;
    @(posedge sys_clk);
    flt <= 1'b1;
    cyc(200);
    chk(reset_n_o, 1'b1, "watchdog fired with open pin");
    flt <= 1'b0;
    $display("test float done");
  endtask
  initial
  begin
    cyc(8);
    rst_n <= 1'b1;
    wait_rst(1'b1, 60, n);
    chk(n >= 20 && n < 60, 1'b1, "power-on reset length");
    t_supply_low();
    t_recover();
    t_ce_pass();
    t_watchdog();
    t_float();
    wrap_up();
  end
  // Tests need about 600 cycles; cut a hang well beyond that
  initial
  begin
    #50us;
    err_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
